// [rtl/channel_capability_report.sv]
// capability report register bank with an axi4-lite slave
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

module channel_capability_report #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // axi4-lite read data
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // reported capability fields
  output      logic [31:0]       buffer_bytes,
  output      logic [31:0]       aen_support,
  output      logic [7:0]        vlan_filter_count,
  output      logic [7:0]        mixed_filter_count,
  output      logic [7:0]        mcast_filter_count,
  output      logic [7:0]        ucast_filter_count,
  output      logic [7:0]        vlan_mode_support,
  output      logic [7:0]        channel_count
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = word_ofs(a);
    mapped = (o == cap_pkg::OFS_BUFFER)  || (o == cap_pkg::OFS_AEN) ||
             (o == cap_pkg::OFS_FILTERS) || (o == cap_pkg::OFS_MODES) ||
             (o == cap_pkg::OFS_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0]       buffer_r;
  logic [31:0]       aen_r;
  logic [31:0]       filters_r;
  logic              mode_mix_r;
  logic              mode_any_r;
  logic [7:0]        chan_r;
  logic              aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic              w_held_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic              do_write;
  logic [7:0]        wofs;
  logic [31:0]       filters_rep;
  logic [31:0]       modes_rep;
  logic              adjusted;

  cap_if cap ();

  cap_limit u_limit (
    .cap (cap)
  );

  assign cap.req_vlan     = filters_r[cap_pkg::POS_VLAN_CNT  +: 8];
  assign cap.req_mixed    = filters_r[cap_pkg::POS_MIXED_CNT +: 8];
  assign cap.req_mcast    = filters_r[cap_pkg::POS_MCAST_CNT +: 8];
  assign cap.req_ucast    = filters_r[cap_pkg::POS_UCAST_CNT +: 8];
  assign cap.req_mode_mix = mode_mix_r;
  assign cap.req_mode_any = mode_any_r;

  // ----------------------------------------------------------------
  // reported words
  // ----------------------------------------------------------------
  always_comb begin
    filters_rep = 32'h0000_0000;
    filters_rep[cap_pkg::POS_VLAN_CNT  +: 8] = cap.rep_vlan;
    filters_rep[cap_pkg::POS_MIXED_CNT +: 8] = cap.rep_mixed;
    filters_rep[cap_pkg::POS_MCAST_CNT +: 8] = cap.rep_mcast;
    filters_rep[cap_pkg::POS_UCAST_CNT +: 8] = cap.rep_ucast;
    modes_rep = 32'h0000_0000;
    modes_rep[cap_pkg::POS_VLAN_MODE +: 8] = cap.rep_vlan_mode;
    modes_rep[cap_pkg::POS_CHAN_CNT  +: 8] = chan_r;
  end

  // status: software request was trimmed to legal range
  assign adjusted = (filters_rep != filters_r);

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign wofs          = word_ofs(awaddr_r);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= cap_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(awaddr_r) ? cap_pkg::RESP_OKAY
                                   : cap_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ----------------------------------------------------------------
  // capability registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      buffer_r <= cap_pkg::RST_BUFFER;
    end else if (do_write && wofs == cap_pkg::OFS_BUFFER) begin
      buffer_r <= merge(buffer_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aen_r <= cap_pkg::RST_AEN;
    end else if (do_write && wofs == cap_pkg::OFS_AEN) begin
      aen_r <= merge(aen_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      filters_r <= {cap_pkg::RST_VLAN_CNT, cap_pkg::RST_MIXED_CNT,
                    cap_pkg::RST_MCAST_CNT, cap_pkg::RST_UCAST_CNT};
    end else if (do_write && wofs == cap_pkg::OFS_FILTERS) begin
      filters_r <= merge(filters_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_mix_r <= cap_pkg::RST_MODE_MIX;
      mode_any_r <= cap_pkg::RST_MODE_ANY;
      chan_r     <= cap_pkg::RST_CHAN_CNT;
    end else if (do_write && wofs == cap_pkg::OFS_MODES) begin
      if (wstrb_r[1]) begin
        mode_mix_r <= wdata_r[cap_pkg::POS_VLAN_MODE +
                              cap_pkg::POS_MODE_MIX];
        mode_any_r <= wdata_r[cap_pkg::POS_VLAN_MODE +
                              cap_pkg::POS_MODE_ANY];
      end
      if (wstrb_r[0]) begin
        chan_r <= wdata_r[cap_pkg::POS_CHAN_CNT +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (word_ofs(s_axi_araddr))
      cap_pkg::OFS_BUFFER:  rdata_nxt = buffer_r;
      cap_pkg::OFS_AEN:     rdata_nxt = aen_r;
      cap_pkg::OFS_FILTERS: rdata_nxt = filters_rep;
      cap_pkg::OFS_MODES:   rdata_nxt = modes_rep;
      cap_pkg::OFS_STATUS:  rdata_nxt = {31'h0000_0000, adjusted};
      default:              rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= cap_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(s_axi_araddr) ? cap_pkg::RESP_OKAY
                                       : cap_pkg::RESP_DECERR;
      rdata_r  <= rdata_nxt;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ----------------------------------------------------------------
  // capability outputs
  // ----------------------------------------------------------------
  assign buffer_bytes  = buffer_r;
  assign aen_support   = aen_r;
  assign channel_count = chan_r;

  // limited counts pass through a flop so the pins never show the
  // settling of the shared-slot arithmetic
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vlan_filter_count  <= cap_pkg::RST_VLAN_CNT;
      mixed_filter_count <= cap_pkg::RST_MIXED_CNT;
      mcast_filter_count <= cap_pkg::RST_MCAST_CNT;
      ucast_filter_count <= cap_pkg::RST_UCAST_CNT;
    end else begin
      vlan_filter_count  <= cap.rep_vlan;
      mixed_filter_count <= cap.rep_mixed;
      mcast_filter_count <= cap.rep_mcast;
      ucast_filter_count <= cap.rep_ucast;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vlan_mode_support <= {5'h00, cap_pkg::RST_MODE_ANY,
                            cap_pkg::RST_MODE_MIX, 1'b1};
    end else begin
      vlan_mode_support <= cap.rep_vlan_mode;
    end
  end

endmodule

// [rtl/cap_pkg.sv]
// constants for the channel capability report register bank
package cap_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BUFFER  = 8'h00;
  localparam logic [7:0] OFS_AEN     = 8'h04;
  localparam logic [7:0] OFS_FILTERS = 8'h08;
  localparam logic [7:0] OFS_MODES   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_VLAN_CNT  = 24;
  localparam int POS_MIXED_CNT = 16;
  localparam int POS_MCAST_CNT = 8;
  localparam int POS_UCAST_CNT = 0;
  localparam int POS_VLAN_MODE = 8;
  localparam int POS_CHAN_CNT  = 0;
  localparam int POS_MODE_ONLY = 0;
  localparam int POS_MODE_MIX  = 1;
  localparam int POS_MODE_ANY  = 2;

  // ----------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------
  localparam logic [7:0] MAX_VLAN_FILTERS = 8'h0f;
  localparam logic [7:0] MAX_MAC_FILTERS  = 8'h08;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_BUFFER     = 32'h0000_0000;
  localparam logic [31:0] RST_AEN        = 32'h0000_0000;
  localparam logic [7:0]  RST_VLAN_CNT   = 8'h00;
  localparam logic [7:0]  RST_MIXED_CNT  = 8'h00;
  localparam logic [7:0]  RST_MCAST_CNT  = 8'h00;
  localparam logic [7:0]  RST_UCAST_CNT  = 8'h01;
  localparam logic        RST_MODE_MIX   = 1'b0;
  localparam logic        RST_MODE_ANY   = 1'b0;
  localparam logic [7:0]  RST_CHAN_CNT   = 8'h01;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// [rtl/cap_if.sv]
// carrier between the register bank and the limit logic
`timescale 1ns/1ps

interface cap_if;

  // requested by software
  logic [7:0] req_vlan;
  logic [7:0] req_mixed;
  logic [7:0] req_mcast;
  logic [7:0] req_ucast;
  logic       req_mode_mix;
  logic       req_mode_any;
  // as reported to the management controller
  logic [7:0] rep_vlan;
  logic [7:0] rep_mixed;
  logic [7:0] rep_mcast;
  logic [7:0] rep_ucast;
  logic [7:0] rep_vlan_mode;

  modport bank  (output req_vlan, req_mixed, req_mcast, req_ucast,
                        req_mode_mix, req_mode_any,
                 input  rep_vlan, rep_mixed, rep_mcast, rep_ucast,
                        rep_vlan_mode);
  modport limit (input  req_vlan, req_mixed, req_mcast, req_ucast,
                        req_mode_mix, req_mode_any,
                 output rep_vlan, rep_mixed, rep_mcast, rep_ucast,
                        rep_vlan_mode);

endinterface

// [rtl/cap_limit.sv]
// limit logic that brings requested counts and modes into legal range
`timescale 1ns/1ps

module cap_limit (
  // requested and reported values
  cap_if.limit cap
);

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  logic [7:0] uc_lim;
  logic [7:0] mx_lim;
  logic [7:0] uc_fix;
  logic [7:0] left;

  // vlan filters never above fifteen
  assign cap.rep_vlan = min8(cap.req_vlan,
                             cap_pkg::MAX_VLAN_FILTERS);

  // unicast first, then mixed, then multicast share the eight slots
  assign uc_lim = min8(cap.req_ucast, cap_pkg::MAX_MAC_FILTERS);
  assign mx_lim = min8(cap.req_mixed,
                       cap_pkg::MAX_MAC_FILTERS - uc_lim);
  // at least one unicast-capable filter always remains
  assign uc_fix = ((uc_lim | mx_lim) == 8'h00) ? 8'h01 : uc_lim;
  assign left   = cap_pkg::MAX_MAC_FILTERS - uc_fix - mx_lim;

  assign cap.rep_ucast = uc_fix;
  assign cap.rep_mixed = mx_lim;
  assign cap.rep_mcast = min8(cap.req_mcast, left);

  // vlan-only always set, upper bits zero
  always_comb begin
    cap.rep_vlan_mode                          = 8'h00;
    cap.rep_vlan_mode[cap_pkg::POS_MODE_ONLY]  = 1'b1;
    cap.rep_vlan_mode[cap_pkg::POS_MODE_MIX]   = cap.req_mode_mix;
    cap.rep_vlan_mode[cap_pkg::POS_MODE_ANY]   = cap.req_mode_any;
  end

endmodule

// [sim/cap_chk.sv]
// assertions on the capability report ports
`timescale 1ns/1ps
module cap_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // reported fields
  input wire logic [31:0] buffer_bytes,
  input wire logic [7:0]  vlan_filter_count,
  input wire logic [7:0]  mixed_filter_count,
  input wire logic [7:0]  mcast_filter_count,
  input wire logic [7:0]  ucast_filter_count,
  input wire logic [7:0]  vlan_mode_support
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_vlan_limit: assert property (vlan_filter_count <= 8'h0f)
    else $error("vlan filter count above fifteen");
  a_mac_total: assert property (10'(ucast_filter_count)
    + 10'(mcast_filter_count) + 10'(mixed_filter_count) <= 10'h8)
    else $error("mac filter total above eight");
  a_ucast_min: assert property (ucast_filter_count != 8'h0
    || mixed_filter_count != 8'h0)
    else $error("no unicast capable filter");
  a_mode_only: assert property (vlan_mode_support[0])
    else $error("vlan only mode bit clear");
  a_mode_rsvd: assert property (vlan_mode_support[7:3] == 5'h0)
    else $error("reserved mode bits set");
  a_buf_reset: assert property ($rose(reset_n) |->
    buffer_bytes == 32'h0 && vlan_mode_support == 8'h01)
    else $error("reset values wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read answer not retired");
  a_read_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
endmodule

bind channel_capability_report cap_chk u_chk (
  .clock(clock), .reset_n(reset_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .buffer_bytes(buffer_bytes), .vlan_filter_count(vlan_filter_count),
  .mixed_filter_count(mixed_filter_count),
  .mcast_filter_count(mcast_filter_count),
  .ucast_filter_count(ucast_filter_count),
  .vlan_mode_support(vlan_mode_support)
);

// [sim/mgmt_host.sv]
// management side bus master model for the register bank
`timescale 1ns/1ps
module mgmt_host (
  // clock
  input  wire logic        clock,
  // write channels
  output      logic [7:0]  awaddr,
  output      logic        awvalid,
  input  wire logic        awready,
  output      logic [31:0] wdata,
  output      logic [3:0]  wstrb,
  output      logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output      logic        bready,
  // read channels
  output      logic [7:0]  araddr,
  output      logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output      logic        rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // released address and write data lines carry the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clock);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid && bready) begin
        done = 1'b1;
        r    = bresp;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid && rready) begin
        done = 1'b1;
        d    = rdata;
        r    = rresp;
      end
    end
    rready <= 1'b0;
  endtask
endmodule

// [sim/tb_channel_capability_report.sv]
// self-checking bench for the capability report register bank
`timescale 1ns/1ps
module tb_channel_capability_report;
  logic        clock, reset_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, exp_mix, exp_any;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb, s;
  logic [7:0]  awaddr, araddr, vlan_cnt, mixed_cnt, mcast_cnt, ucast_cnt;
  logic [7:0]  mode_sup, chan_cnt, exp_cc;
  logic [31:0] wdata, rdata, buf_val, aen_val, got, d;
  logic [31:0] exp_buf, exp_aen, exp_filt;
  logic [31:0] cases[$];
  int          error_cnt, check_count, cycles;

  channel_capability_report dut (
    .clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .buffer_bytes(buf_val), .aen_support(aen_val),
    .vlan_filter_count(vlan_cnt), .mixed_filter_count(mixed_cnt),
    .mcast_filter_count(mcast_cnt), .ucast_filter_count(ucast_cnt),
    .vlan_mode_support(mode_sup), .channel_count(chan_cnt)
  );

  mgmt_host host (
    .clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  // ----------------------------------------------------------------
  // model and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lim(input logic [31:0] q);
    int v, m, mc, u;
    v  = q[31:24];
    m  = q[23:16];
    mc = q[15:8];
    u  = q[7:0];
    if (v > 15) v = 15;
    if (u > 8) u = 8;
    if (m > 8 - u) m = 8 - u;
    if (u == 0 && m == 0) u = 1;
    if (mc > 8 - u - m) mc = 8 - u - m;
    return {8'(v), 8'(m), 8'(mc), 8'(u)};
  endfunction

  function automatic logic [31:0] mode_word();
    return {16'h0, 5'h0, exp_any, exp_mix, 1'b1, exp_cc};
  endfunction

  task automatic chk_d(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_r(input string n, input logic [1:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    host.rd(a, got, resp);
    chk_r("rresp", er, resp);
    chk_d("rdata", e, got);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] v,
                        input logic [3:0] st, input logic [1:0] er);
    host.wr(a, v, st, resp);
    chk_r("bresp", er, resp);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, error_cnt, check_count, cycles} = '0;
    void'($urandom(32'h8db051e9));
    {exp_buf, exp_aen, exp_mix, exp_any} = '0;
    exp_filt = 32'h1;
    exp_cc   = 8'h01;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(8'h00, exp_buf, 2'b00);
    rd_chk(8'h04, exp_aen, 2'b00);
    rd_chk(8'h08, exp_filt, 2'b00);
    rd_chk(8'h0c, mode_word(), 2'b00);
    wr_chk(8'h10, 32'hffffffff, 4'hf, 2'b00);
    rd_chk(8'h10, 32'h0, 2'b00);
    wr_chk(8'h14, 32'hffffffff, 4'hf, 2'b11);
    rd_chk(8'h14, 32'h0, 2'b11);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      s = 4'($urandom);
      wr_chk(8'h00, d, s, 2'b00);
      for (int b = 0; b < 4; b++)
        if (s[b]) exp_buf[8*b+:8] = d[8*b+:8];
      rd_chk(8'h00, exp_buf, 2'b00);
      chk_d("buffer_bytes", exp_buf, buf_val);
      exp_aen = ~d;
      wr_chk(8'h04, exp_aen, 4'hf, 2'b00);
      chk_d("aen_support", exp_aen, aen_val);
    end
    $display("test buffer and event done");
    cases = {32'h10000000, 32'h0f000008, 32'h00080000, 32'h00050505,
             32'hffffffff, 32'h01020303, 32'h000000ff};
    repeat (8) cases.push_back($urandom & 32'h1f0f0f0f);
    foreach (cases[i]) begin
      wr_chk(8'h08, cases[i], 4'hf, 2'b00);
      exp_filt = lim(cases[i]);
      rd_chk(8'h08, exp_filt, 2'b00);
      chk_d("counts", exp_filt,
            {vlan_cnt, mixed_cnt, mcast_cnt, ucast_cnt});
      rd_chk(8'h10, {31'h0, exp_filt != cases[i]}, 2'b00);
    end
    $display("test filter counts done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[10:9] = 2'(i);
      wr_chk(8'h0c, d, 4'hf, 2'b00);
      {exp_any, exp_mix} = d[10:9];
      exp_cc = d[7:0];
      rd_chk(8'h0c, mode_word(), 2'b00);
      chk_d("modes", mode_word(), {16'h0, mode_sup, chan_cnt});
    end
    $display("test vlan modes done");
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(8'h00, 32'h0, 2'b00);
    rd_chk(8'h08, 32'h1, 2'b00);
    rd_chk(8'h0c, 32'h0000_0101, 2'b00);
    $display("test second reset done");
    stop_test();
  end
endmodule
